// [hdl/tx_cfg.svh]
// offsets, field positions and reset values of the serial transmitter
`ifndef TX_CFG_SVH
`define TX_CFG_SVH

// byte offsets on the register bus
`define TXSC_OFS     5'h00
`define RXSC_OFS     5'h04
`define BAUDC_OFS    5'h08
`define DIVLO_OFS    5'h0c
`define DIVHI_OFS    5'h10
`define HOLD_OFS     5'h14
`define INTC_OFS     5'h18

// transmit status/control fields
`define TXSC_NINTH_EN   6
`define TXSC_TX_EN      5
`define TXSC_CLOCKED    4
`define TXSC_HIGH_SPEED 2
`define TXSC_SHIFT_MT   1
`define TXSC_NINTH_VAL  0

// receive status/control field
`define RXSC_PORT_EN    7

// baud control fields
`define BAUDC_POLARITY  4
`define BAUDC_WIDE_DIV  3

// interrupt control fields
`define INTC_TX_IE      0
`define INTC_PERIPH_IE  1
`define INTC_GLOBAL_IE  2
`define INTC_TX_FLAG    4

// reset values
`define DIV_RESET       8'h00
`define WAIT_RESET      1'b1

`endif

// [hdl/tx_pkg.sv]
// types shared by the serial transmitter
package tx_pkg;

  // shifter states, gray coded along idle-start-data-stop
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_start = 2'b01,
    st_data  = 2'b11,
    st_stop  = 2'b10
  } shift_state_t;

  // software control bits
  typedef struct packed {
    logic ninth_bit_enable;
    logic transmit_enable;
    logic clocked_mode;
    logic high_speed_baud_select;
    logic ninth_bit_value;
    logic serial_port_enable;
    logic polarity_select;
    logic wide_divisor_select;
    logic transmit_interrupt_enable;
    logic peripheral_interrupt_enable;
    logic global_interrupt_enable;
  } ctrl_t;

  // one queued character
  typedef struct packed {
    logic       full;
    logic       ninth;
    logic [7:0] data;
  } hold_t;

endpackage

// [hdl/async_serial_transmitter.sv]
// asynchronous serial transmitter with avalon-mm register slave
//
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "tx_cfg.svh"

// Contract
// - runs only when enabled, async, port on
// - port enable drives transmit pin as output
// - buffer empty flag sets with transmit enable
// - holding write starts transmission, loads if idle
// - queued character loads one cycle after stop
// - start, data, stop follow load at once
// - polarity zero idles high, one inverts line
// - inversion applies in asynchronous mode only
// - flag set unless character queued behind busy or parked shifter
// - flag changes from second cycle after write
// - flag is read only
// - flag independent of interrupt enable
// - shift empty clears on load until done
// - shift empty is polled, no interrupt
// - nine data bits, stored bit most significant
// - nine bits move together on load
// - enable with flag set raises interrupt
// - low start, data, high stop, mark idle
// - least significant first, one tick per bit
module async_serial_transmitter
  import tx_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // avalon-mm slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // baud generator side
  input  wire logic        baud_tick,
  output logic      [15:0] baud_divisor,
  output logic             high_speed_baud_select,
  output logic             wide_divisor_select,
  output logic             baud_restart,
  // transmit pin
  output logic             tx_pin_out,
  output logic             tx_pin_oe,
  // interrupt request toward the core
  output logic             tx_irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ctrl_t        ctrl_reg;
  ctrl_t        ctrl_next;
  hold_t        hold_reg;
  hold_t        hold_next;
  shift_state_t state_reg;
  shift_state_t state_next;
  logic [8:0]   shift_reg;
  logic [8:0]   shift_next;
  logic [3:0]   bitcnt_reg;
  logic [3:0]   bitcnt_next;
  logic         nine_reg;
  logic [7:0]   div_lo_reg;
  logic [7:0]   div_hi_reg;
  logic         flag_reg;
  logic         wait_reg;
  logic [31:0]  rdata_reg;
  logic         pin_reg;
  logic         oe_reg;
  logic         irq_reg;
  logic         restart_reg;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // a request is taken on the edge where waitrequest is low
  wire logic acc      = (read | write) & ~wait_reg;
  // only the low byte lane carries register bits; a write with that lane
  // masked off is accepted on the bus but changes nothing
  wire logic wr_acc   = write & acc & byteenable[0];
  wire logic hit_txsc = (address == `TXSC_OFS);
  wire logic hit_rxsc = (address == `RXSC_OFS);
  wire logic hit_baud = (address == `BAUDC_OFS);
  wire logic hit_dlo  = (address == `DIVLO_OFS);
  wire logic hit_dhi  = (address == `DIVHI_OFS);
  wire logic hit_hold = (address == `HOLD_OFS);
  wire logic hit_intc = (address == `INTC_OFS);
  wire logic [7:0] wd = writedata[7:0];

  // ----------------------------------------------------------------
  // mode and handshake with the shifter
  // ----------------------------------------------------------------
  // transmitter runs only in the enabled asynchronous configuration;
  // clocked mode is not built here, setting it parks the shifter and turns off inversion
  wire logic active = ctrl_reg.transmit_enable
                    & ~ctrl_reg.clocked_mode
                    & ctrl_reg.serial_port_enable;
  // queued character moves in only while the shifter is free
  wire logic load = active & hold_reg.full & (state_reg == st_idle);
  wire logic hold_wr = wr_acc & hit_hold;
  wire logic last_bit = (bitcnt_reg == (nine_reg ? 4'h8 : 4'h7));
  wire logic shift_empty = (state_reg == st_idle);
  // a character counts as queued only while it waits behind a busy or parked
  // shifter; the cycle in which it is loaded already counts as empty, so
  // a write to an idle shifter never makes the flag blink low
  wire logic queued = hold_reg.full & ~load;

  // ----------------------------------------------------------------
  // control register writes
  // ----------------------------------------------------------------
  // the status bits (shift empty, buffer empty) have no write path
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_acc && hit_txsc) begin
      ctrl_next.ninth_bit_enable       = wd[`TXSC_NINTH_EN];
      ctrl_next.transmit_enable        = wd[`TXSC_TX_EN];
      ctrl_next.clocked_mode           = wd[`TXSC_CLOCKED];
      ctrl_next.high_speed_baud_select = wd[`TXSC_HIGH_SPEED];
      ctrl_next.ninth_bit_value        = wd[`TXSC_NINTH_VAL];
    end else if (wr_acc && hit_rxsc) begin
      ctrl_next.serial_port_enable = wd[`RXSC_PORT_EN];
    end else if (wr_acc && hit_baud) begin
      ctrl_next.polarity_select     = wd[`BAUDC_POLARITY];
      ctrl_next.wide_divisor_select = wd[`BAUDC_WIDE_DIV];
    end else if (wr_acc && hit_intc) begin
      ctrl_next.transmit_interrupt_enable   = wd[`INTC_TX_IE];
      ctrl_next.peripheral_interrupt_enable = wd[`INTC_PERIPH_IE];
      ctrl_next.global_interrupt_enable     = wd[`INTC_GLOBAL_IE];
    end
  end

  // ----------------------------------------------------------------
  // holding register
  // ----------------------------------------------------------------
  // a write wins over the load of the same cycle: the load takes the
  // old character and the new one stays queued behind it; clearing the
  // enable or the port drops a queued character, so a later re-enable
  // never sends stale data
  always_comb begin
    hold_next = hold_reg;
    if (load) begin
      hold_next.full = 1'b0;
    end
    if (hold_wr) begin
      hold_next.full  = 1'b1;
      hold_next.data  = wd;
      hold_next.ninth = ctrl_reg.ninth_bit_value;
    end
    if (!ctrl_reg.transmit_enable || !ctrl_reg.serial_port_enable) begin
      hold_next.full = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // shifter state machine
  // ----------------------------------------------------------------
  // every bit holds until the next baud tick; leaving the asynchronous
  // mode mid-frame cuts the frame short and the line returns to mark at
  // once, which the far receiver sees as a framing error
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_idle: begin
        if (load) begin
          state_next = st_start;
        end
      end
      st_start: begin
        if (baud_tick) begin
          state_next = st_data;
        end
      end
      st_data: begin
        if (baud_tick && last_bit) begin
          state_next = st_stop;
        end
      end
      st_stop: begin
        if (baud_tick) begin
          state_next = st_idle;
        end
      end
      default: begin
        state_next = st_idle;
      end
    endcase
    if (!active) begin
      state_next = st_idle;
    end
  end

  // ----------------------------------------------------------------
  // shift data and bit counter
  // ----------------------------------------------------------------
  // data leaves from bit 0, so the lsb goes first
  // in eight-bit mode the ninth bit is loaded too but never reaches the line
  always_comb begin
    shift_next  = shift_reg;
    bitcnt_next = bitcnt_reg;
    if (load) begin
      shift_next  = {hold_reg.ninth, hold_reg.data};
      bitcnt_next = 4'h0;
    end else if (state_reg == st_data && baud_tick) begin
      shift_next  = {1'b0, shift_reg[8:1]};
      bitcnt_next = bitcnt_reg + 4'h1;
    end
  end

  // level on the line before polarity: space start, mark stop and idle
  wire logic line_raw = (state_reg == st_start) ? 1'b0 :
                        (state_reg == st_data)  ? shift_reg[0] :
                        1'b1;
  // inversion only counts in asynchronous mode
  wire logic invert = ctrl_reg.polarity_select & ~ctrl_reg.clocked_mode;

  // ----------------------------------------------------------------
  // read data mux
  // ----------------------------------------------------------------
  // holding register is write only and reads as zero, like any hole
  // shift empty is read straight from the shifter state; buffer empty is read from flag_reg
  wire logic [7:0] rd_txsc = {1'b0,
                              ctrl_reg.ninth_bit_enable,
                              ctrl_reg.transmit_enable,
                              ctrl_reg.clocked_mode,
                              1'b0,
                              ctrl_reg.high_speed_baud_select,
                              shift_empty,
                              ctrl_reg.ninth_bit_value};
  wire logic [7:0] rd_rxsc = {ctrl_reg.serial_port_enable, 7'h00};
  wire logic [7:0] rd_baud = {3'h0,
                              ctrl_reg.polarity_select,
                              ctrl_reg.wide_divisor_select,
                              3'h0};
  wire logic [7:0] rd_intc = {3'h0,
                              flag_reg,
                              1'b0,
                              ctrl_reg.global_interrupt_enable,
                              ctrl_reg.peripheral_interrupt_enable,
                              ctrl_reg.transmit_interrupt_enable};
  logic [7:0] rd_byte;
  always_comb begin
    if (hit_txsc) begin
      rd_byte = rd_txsc;
    end else if (hit_rxsc) begin
      rd_byte = rd_rxsc;
    end else if (hit_baud) begin
      rd_byte = rd_baud;
    end else if (hit_dlo) begin
      rd_byte = div_lo_reg;
    end else if (hit_dhi) begin
      rd_byte = div_hi_reg;
    end else if (hit_intc) begin
      rd_byte = rd_intc;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // one wait state per access so read data come from a flop
  // the read mux is sampled in the wait cycle, while the address still
  // stands, which keeps the decode off the readdata timing path
  always_ff @(posedge clk) begin
    if (srst) begin
      wait_reg  <= `WAIT_RESET;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg  <= ~((read | write) & wait_reg);
      rdata_reg <= (read & wait_reg) ? {24'h00_0000, rd_byte} : rdata_reg;
    end
  end

  // ----------------------------------------------------------------
  // configuration and holding state
  // ----------------------------------------------------------------
  // everything resets to zero: normal polarity, port off, transmitter off
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= '0;
      hold_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      hold_reg <= hold_next;
    end
  end

  // divisor pair only feeds the external generator
  // the generator takes a new divisor on its own; only baud_restart realigns it
  always_ff @(posedge clk) begin
    if (srst) begin
      div_lo_reg <= `DIV_RESET;
      div_hi_reg <= `DIV_RESET;
    end else begin
      div_lo_reg <= (wr_acc && hit_dlo) ? wd : div_lo_reg;
      div_hi_reg <= (wr_acc && hit_dhi) ? wd : div_hi_reg;
    end
  end

  // ----------------------------------------------------------------
  // shifter registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg  <= st_idle;
      shift_reg  <= 9'h000;
      bitcnt_reg <= 4'h0;
      nine_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      shift_reg  <= shift_next;
      bitcnt_reg <= bitcnt_next;
      nine_reg   <= load ? ctrl_reg.ninth_bit_enable : nine_reg;
    end
  end

  // ----------------------------------------------------------------
  // status flag and interrupt
  // ----------------------------------------------------------------
  // flag follows the holding register one edge late, so a write is
  // seen from the second cycle after it; interrupt enable does not touch it
  // the interrupt adds one more flop, so it trails the flag by a cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      flag_reg <= 1'b0;
      irq_reg  <= 1'b0;
    end else begin
      flag_reg <= ctrl_reg.transmit_enable & ~queued;
      irq_reg  <= flag_reg
                & ctrl_reg.transmit_interrupt_enable
                & ctrl_reg.peripheral_interrupt_enable
                & ctrl_reg.global_interrupt_enable;
    end
  end

  // ----------------------------------------------------------------
  // pin and generator outputs
  // ----------------------------------------------------------------
  // restart lines the bit period up with the start bit
  // the pin is registered like every output, so the line trails the
  // shifter state by one clock; every bit still keeps its full length
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_reg     <= 1'b1;
      oe_reg      <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      pin_reg     <= line_raw ^ invert;
      oe_reg      <= ctrl_reg.serial_port_enable;
      restart_reg <= load;
    end
  end

  assign readdata               = rdata_reg;
  assign waitrequest            = wait_reg;
  assign baud_divisor           = {div_hi_reg, div_lo_reg};
  assign high_speed_baud_select = ctrl_reg.high_speed_baud_select;
  assign wide_divisor_select    = ctrl_reg.wide_divisor_select;
  assign baud_restart           = restart_reg;
  assign tx_pin_out             = pin_reg;
  assign tx_pin_oe              = oe_reg;
  assign tx_irq                 = irq_reg;

endmodule // async_serial_transmitter
`default_nettype wire

// [verif/tx_port_chk.sv]
// port-level assertions for the serial transmitter
`timescale 1ns/1ns
`default_nettype none
`include "tx_cfg.svh"
module tx_port_chk (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // register bus
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic        waitrequest,
  // line side
  input  wire logic        baud_tick,
  input  wire logic        baud_restart,
  input  wire logic        tx_pin_out,
  input  wire logic        tx_pin_oe,
  input  wire logic        tx_irq
);
  // --------------------------------------------------------------------
  // accepted accesses
  // --------------------------------------------------------------------
  logic acc_wr;
  logic hold_wr;
  assign acc_wr  = write & ~waitrequest;
  assign hold_wr = acc_wr & (address == `HOLD_OFS);

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // a request rising on the bus
  sequence s_req_up;
    $rose(read | write);
  endsequence
  // no tick, load or register write recently that could move the line
  sequence s_line_quiet;
    !$past(baud_restart) && !$past(baud_tick) && !$past(baud_tick, 2) && $past(waitrequest)
      && $past(waitrequest, 2) && $past(waitrequest, 3);
  endsequence

  a_wait_once: assert property (s_req_up |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest not low for exactly one cycle");
  a_restart_pulse: assert property (baud_restart |=> !baud_restart)
    else $error("baud restart longer than one cycle");
  a_start_edge: assert property (baud_restart |=> tx_pin_out != $past(tx_pin_out))
    else $error("start bit not on line with restart");
  a_restart_cause: assert property (baud_restart |-> $past(hold_wr, 2) || $past(baud_tick, 2))
    else $error("load without holding write or stop tick");
  a_bit_hold: assert property (s_line_quiet |-> $stable(tx_pin_out))
    else $error("line moved between bit ticks");
  a_irq_rise: assert property ($rose(tx_irq) |-> $past(acc_wr, 2) || $past(acc_wr, 3)
    || $past(baud_tick, 3) || $past(baud_tick, 4))
    else $error("interrupt rose without cause");
  a_irq_fall: assert property ($fell(tx_irq) |-> $past(acc_wr, 2) || $past(acc_wr, 3)
    || $past(acc_wr, 4))
    else $error("interrupt fell without a register write");
  a_oe_rise: assert property ($rose(tx_pin_oe) |-> $past(acc_wr, 2) || $past(acc_wr, 3))
    else $error("pin enable rose without a register write");
endmodule // tx_port_chk

bind async_serial_transmitter tx_port_chk u_chk (
  .clk(clk), .srst(srst), .address(address), .read(read), .write(write),
  .waitrequest(waitrequest), .baud_tick(baud_tick), .baud_restart(baud_restart),
  .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .tx_irq(tx_irq)
);
`default_nettype wire

// [verif/line_receiver.sv]
// remote receiver model that decodes frames from the transmit pin
`timescale 1ns/1ns
`default_nettype none
module line_receiver (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // line and bit timing
  input  wire logic       line,
  input  wire logic       baud_tick,
  input  wire logic       invert,
  input  wire logic       nine,
  // received character
  output logic      [8:0] rx_data,
  output logic            rx_err,
  output logic            rx_done
);
  logic [3:0] bit_reg;
  logic       busy_reg;
  logic       lvl;
  assign lvl = line ^ invert;  // undo line inversion
  // sample each bit at the tick that ends it; no oversampling, the bench shares the tick
  always_ff @(posedge clk) begin
    rx_done <= 1'b0;
    if (srst) begin
      busy_reg <= 1'b0;
      bit_reg  <= 4'h0;
      rx_err   <= 1'b0;
    end else if (!busy_reg) begin
      busy_reg <= !lvl;  // space level opens a frame
      bit_reg  <= 4'h0;
    end else if (baud_tick) begin
      bit_reg <= bit_reg + 4'h1;
      if (bit_reg == 4'h0) begin
        rx_err <= lvl;  // start bit is a space
      end else if (bit_reg <= 4'h8 + {3'h0, nine}) begin
        rx_data <= {lvl, rx_data[8:1]};  // lsb first
      end else begin
        if (!nine) rx_data <= {1'b0, rx_data[8:1]};
        rx_err   <= rx_err | !lvl;  // stop bit is a mark
        rx_done  <= 1'b1;
        busy_reg <= 1'b0;
      end
    end
  end
endmodule // line_receiver
`default_nettype wire

// [verif/async_serial_transmitter_test.sv]
// self-checking bench for the serial transmitter
`timescale 1ns/1ns
`default_nettype none
`include "tx_cfg.svh"
`define CHK(name, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("[FAIL] %s expected %h seen %h", name, exp, got); \
    end \
  end
module async_serial_transmitter_test;
  import tx_pkg::*;
  localparam int DIV = 8;  // short bit period keeps the run brief
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [4:0]  address = 5'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'h1;
  logic        baud_tick = 1'b0;
  logic [3:0]  tick_cnt = 4'h0;
  logic        rx_clr = 1'b1;
  logic        invert = 1'b0;
  logic        nine = 1'b0;
  logic [31:0] readdata;
  logic [15:0] baud_divisor;
  logic        waitrequest, baud_restart, tx_pin_out, tx_pin_oe, tx_irq, rx_err, rx_done;
  logic [8:0]  rx_data;
  logic        hs_sel, wd_sel;
  logic [7:0]  rv, base, d1, d2;
  logic [15:0] rnd = 16'h5bc4;  // seed 23492
  int          error_cnt = 0;
  int          n_tests = 0;

  async_serial_transmitter u_dut (.clk(clk), .srst(srst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .baud_tick(baud_tick), .baud_divisor(baud_divisor),
    .high_speed_baud_select(hs_sel), .wide_divisor_select(wd_sel), .baud_restart(baud_restart),
    .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .tx_irq(tx_irq));
  line_receiver u_rx (.clk(clk), .srst(rx_clr), .line(tx_pin_out), .baud_tick(baud_tick),
    .invert(invert), .nine(nine), .rx_data(rx_data), .rx_err(rx_err), .rx_done(rx_done));

  // --------------------------------------------------------------------
  // clock, bit tick and helpers
  // --------------------------------------------------------------------
  always #2 clk = ~clk;
  // bit tick generator realigns on every load, as a real divider would
  always @(posedge clk) begin
    tick_cnt  <= (baud_restart || tick_cnt == 4'(DIV - 1)) ? 4'h0 : tick_cnt + 4'h1;
    baud_tick <= (tick_cnt == 4'(DIV - 1)) && !baud_restart;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [8:0] frame_val(input logic n9, input logic b9, input logic [7:0] d);
    return {n9 & b9, d};  // ninth bit only travels in nine-bit mode
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one avalon access held until waitrequest is sampled low, then a short gap
  task automatic bus(input logic wr_n_rd, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int k;
    address   <= a;
    writedata <= {24'h0, d};
    write     <= wr_n_rd;
    read      <= !wr_n_rd;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      error_cnt++;
      print_verdict();
    end
    q = readdata[7:0];
    write <= 1'b0;
    read  <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic expect_char(input logic [8:0] e);
    int k;
    for (k = 0; k < 400 && rx_done !== 1'b1; k++) @(posedge clk);
    if (k == 400) begin
      error_cnt++;
      print_verdict();
    end
    `CHK("received char", e, rx_data)
    `CHK("framing", 1'b0, rx_err)
    @(posedge clk);
  endtask

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    bus(1'b0, `TXSC_OFS, 8'h00, rv);
    `CHK("status at reset", 8'h02, rv)
    bus(1'b0, 5'h1c, 8'h00, rv);
    `CHK("unmapped read", 8'h00, rv)
    `CHK("pin released", 1'b0, tx_pin_oe)
    wr(`DIVLO_OFS, rnd[7:0]);
    `CHK("divisor low", rnd[7:0], baud_divisor[7:0])
    byteenable <= 4'h0;
    wr(`DIVHI_OFS, rnd[15:8]);
    byteenable <= 4'h1;
    `CHK("divisor lane off", 8'h00, baud_divisor[15:8])
    wr(`DIVHI_OFS, rnd[15:8]);
    `CHK("divisor high", rnd[15:8], baud_divisor[15:8])
    wr(`BAUDC_OFS, 8'h08);
    `CHK("wide divisor", 1'b1, wd_sel)
    wr(`RXSC_OFS, 8'h80);
    `CHK("pin driven", 1'b1, tx_pin_oe)
    wr(`TXSC_OFS, 8'h24);
    `CHK("high speed", 1'b1, hs_sel)
    bus(1'b0, `INTC_OFS, 8'h00, rv);
    `CHK("flag on enable", 8'h10, rv)
    wr(`INTC_OFS, 8'h00);
    bus(1'b0, `INTC_OFS, 8'h00, rv);
    `CHK("flag read only", 8'h10, rv)
    wr(`INTC_OFS, 8'h07);
    `CHK("irq on enable", 1'b1, tx_irq)
    // every width and polarity, back-to-back characters, 00/ff data in mode 0 then random data
    for (int m = 0; m < 4; m++) begin
      base = m[0] ? 8'h60 : 8'h20;
      rx_clr <= 1'b1;
      wr(`TXSC_OFS, base);
      wr(`BAUDC_OFS, {3'h0, m[1], 4'h0});
      nine   <= m[0];
      invert <= m[1];
      rx_clr <= 1'b0;
      `CHK("idle level", !m[1], tx_pin_out)
      wr(`INTC_OFS, 8'h07);
      `CHK("irq re-enabled", 1'b1, tx_irq)
      rnd = lfsr_next(rnd);
      d1 = (m == 0) ? 8'h00 : rnd[7:0];
      d2 = (m == 0) ? 8'hff : rnd[15:8];
      wr(`TXSC_OFS, base | {7'h0, rnd[3]});
      wr(`HOLD_OFS, d1);
      bus(1'b0, `INTC_OFS, 8'h00, rv);
      `CHK("flag after load", 8'h17, rv)
      bus(1'b0, `TXSC_OFS, 8'h00, rv);
      `CHK("shift busy", base | {7'h0, rnd[3]}, rv)
      wr(`TXSC_OFS, base | {7'h0, rnd[9]});
      wr(`HOLD_OFS, d2);
      bus(1'b0, `INTC_OFS, 8'h00, rv);
      `CHK("flag queued", 8'h07, rv)
      `CHK("irq queued", 1'b0, tx_irq)
      wr(`INTC_OFS, 8'h06);
      expect_char(frame_val(m[0], rnd[3], d1));
      expect_char(frame_val(m[0], rnd[9], d2));
      `CHK("irq after reload", 1'b0, tx_irq)
      bus(1'b0, `TXSC_OFS, 8'h00, rv);
      `CHK("shift empty", base | {6'h0, 1'b1, rnd[9]}, rv)
      $display("mode %0d done", m);
    end
    // clocked mode blocks asynchronous sending
    wr(`TXSC_OFS, 8'h30);
    wr(`HOLD_OFS, 8'h5a);
    repeat (DIV * 4) @(posedge clk);
    `CHK("clocked polarity", 1'b1, tx_pin_out)
    bus(1'b0, `TXSC_OFS, 8'h00, rv);
    `CHK("clocked mode idle", 8'h32, rv)
    wr(`RXSC_OFS, 8'h00);
    `CHK("port off", 1'b0, tx_pin_oe)
    $display("control tests done");
    print_verdict();
  end
endmodule // async_serial_transmitter_test
`default_nettype wire
